// ### gdsr_status_bank.v
// read-only status register bank of a three-phase gate driver
// Summary of operation
// - status bit 15 reads 1 after reset, 0 once any serial fault latched
// - status bit 14 is OR of all fault flags except user memory and tracks fault pin
// - status bit 13 is OR of warning flags except overtemperature warning
// - bits 12..8 OR drain-source, gate, sense, overvoltage, undervoltage flags
// - status bit 1 set on overtemperature warning event
// - status bit 0 mirrors driver enable control bit
// - limit counter counts overcurrents when enabled; bit 15 set when nonzero
// - overcurrent bits 10..8 are sense overcurrent phases A, B, C
// - overcurrent bits 5..0 are drain-source faults AH AL BH BL CH CL
// - gate fault bits 5..0 are AH AL BH BL CH CL
// - supply bits 15..8 supply pairs; bits 5..0 bootstrap pairs A B C
// - interface bit 14 flags power supply undervoltage warning
// - interface bit 10 reads 0 for charge pump, 1 for linear mode
// - interface bits 8, 7, 6 flag watchdog, checksum and address errors
// - with checksum on and long mode off, clock fault unless frame had 0 or 32 clocks
// - 24-bit frames need 0 or 24 clocks, 96-bit frames 0 or 96
// - interface bit 4 flags factory memory checksum fault
// - bit 3 user memory fault; set when unprogrammed; never drives fault pin
// - interface bit 1 shoot-through violation, bit 0 dead-time violation
// - monitor bits 15, 14, 13 flag phase compare faults A, B, C
// - monitor bits 11,10,9,7,4,3,0 flag reference, regulator, supply, test faults
// - latched flags stay set until the clear-faults command
// - first bit of every response word equals summary fault bit
`timescale 1ns/1ps
`include "gdsr_regs.vh"

module gdsr_status_bank (
   input wire core_clk_i, // 125 mhz core clock
   input wire rst_i, // synchronous reset, active high
   input wire clear_faults_cmd_i, // one-cycle clear of latched flags
   input wire driver_enable_ctrl_i, // driver enable control bit
   input wire cycle_limit_enable_i, // cycle-by-cycle limiting enabled
   input wire [5:0] ds_overcurrent_i, // drain-source events ah al bh bl ch cl
   input wire [2:0] sense_overcurrent_i, // sense events a b c
   input wire [5:0] gate_fault_i, // gate fault events ah al bh bl ch cl
   input wire [7:0] supply_ov_uv_i, // power, drain, pump, gate ov/uv pairs
   input wire [5:0] bootstrap_ov_uv_i, // bootstrap ov/uv pairs a b c
   input wire power_supply_under_warning_i, // supply undervoltage warning
   input wire gate_supply_regulator_mode_i, // 1 while gate supply runs linear
   input wire watchdog_timeout_i, // serial watchdog timeout event
   input wire frame_checksum_error_i, // frame checksum error event
   input wire frame_address_error_i, // frame address error event
   input wire frame_end_i, // pulse at end of a serial frame
   input wire [6:0] frame_clock_count_i, // clocks in the ending frame, saturating
   input wire frame_checksum_enable_i, // 1 selects 32-clock frames while frame_long_i is 0
   input wire frame_long_i, // 1 selects 96-clock frames
   input wire factory_memory_checksum_error_i, // factory memory checksum event
   input wire user_memory_checksum_error_i, // user memory checksum event
   input wire user_memory_programmed_i, // 0 while user memory unprogrammed
   input wire shoot_through_violation_i, // shoot-through event
   input wire dead_time_violation_i, // dead-time event
   input wire overtemp_warning_i, // overtemperature warning event
   input wire [2:0] phase_compare_fault_i, // phase compare events a b c
   input wire [6:0] monitor_fault_i, // ref ov, ref uv, sdo uv, digital_supply_over, bist, mode, clk
   input wire [6:0] rd_addr_i, // register address of the read
   input wire rd_en_i, // one-cycle read request
   output reg [15:0] rd_data_o, // read data, valid cycle after rd_en_i
   output reg rd_valid_o, // pulse marking rd_data_o
   output reg response_fault_bit_o, // leading bit of each response word
   output reg fault_out_n_o // fault pin level, low while any fault other than user memory latched
);

   reg [5:0] ds_r;
   reg [2:0] sns_r;
   reg [5:0] gs_r;
   reg [7:0] sup_r;
   reg [5:0] bst_r;
   reg psu_warn_r;
   reg wdt_r;
   reg crc_r;
   reg addr_r;
   reg clk_r;
   reg fact_r;
   reg user_r;
   reg shoot_r;
   reg dead_r;
   reg otw_r;
   reg [2:0] phc_r;
   reg [6:0] mon_r;
   reg [`GDSR_CNT_W-1:0] limit_cnt_r;
   reg [`GDSR_CNT_W-1:0] limit_cnt_nxt;
   reg clk_bad;
   reg [15:0] sel_data;
   wire clr;
   wire any_oc;
   wire [15:0] summary;
   wire [15:0] overcurrent;
   wire [15:0] gate_fault;
   wire [15:0] supply;
   wire [15:0] iface_mem;
   wire [15:0] monitor;
   wire fault_any;
   wire warn_any;
   wire ov_any;
   wire uv_any;

   // sticky set: an event wins over a clear arriving in the same cycle
   function latch_bit;
      input cur;
      input evt;
      input clear;
      begin
         latch_bit = evt | (cur & ~clear);
      end
   endfunction

   assign clr = clear_faults_cmd_i;
   assign any_oc = (|ds_overcurrent_i) | (|sense_overcurrent_i);

   // frame clock count check; zero clocks is never an error
   always @* begin
      if (frame_clock_count_i == 7'h00) begin
         clk_bad = 1'b0;
      end else if (frame_long_i) begin
         clk_bad = (frame_clock_count_i != `GDSR_CLKS_LONG);
      end else if (frame_checksum_enable_i) begin
         clk_bad = (frame_clock_count_i != `GDSR_CLKS_CRC);
      end else begin
         clk_bad = (frame_clock_count_i != `GDSR_CLKS_NOCRC);
      end
   end

   // latched detail flags; all hold until the clear command
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         ds_r <= 6'h00;
         sns_r <= 3'h0;
         gs_r <= 6'h00;
         sup_r <= 8'h00;
         bst_r <= 6'h00;
         psu_warn_r <= 1'b0;
         wdt_r <= 1'b0;
         crc_r <= 1'b0;
         addr_r <= 1'b0;
         clk_r <= 1'b0;
         fact_r <= 1'b0;
         user_r <= 1'b0;
         shoot_r <= 1'b0;
         dead_r <= 1'b0;
         otw_r <= 1'b0;
         phc_r <= 3'h0;
         mon_r <= 7'h00;
      end else begin
         ds_r <= ds_overcurrent_i | (ds_r & {6{~clr}});
         sns_r <= sense_overcurrent_i | (sns_r & {3{~clr}});
         gs_r <= gate_fault_i | (gs_r & {6{~clr}});
         sup_r <= supply_ov_uv_i | (sup_r & {8{~clr}});
         bst_r <= bootstrap_ov_uv_i | (bst_r & {6{~clr}});
         psu_warn_r <= latch_bit(psu_warn_r, power_supply_under_warning_i, clr);
         wdt_r <= latch_bit(wdt_r, watchdog_timeout_i, clr);
         crc_r <= latch_bit(crc_r, frame_checksum_error_i, clr);
         addr_r <= latch_bit(addr_r, frame_address_error_i, clr);
         clk_r <= latch_bit(clk_r, frame_end_i & clk_bad, clr);
         fact_r <= latch_bit(fact_r, factory_memory_checksum_error_i, clr);
         // unprogrammed user memory re-raises the flag; software clears it once
         user_r <= latch_bit(user_r, user_memory_checksum_error_i |
                             ~user_memory_programmed_i, clr);
         shoot_r <= latch_bit(shoot_r, shoot_through_violation_i, clr);
         dead_r <= latch_bit(dead_r, dead_time_violation_i, clr);
         otw_r <= latch_bit(otw_r, overtemp_warning_i, clr);
         phc_r <= phase_compare_fault_i | (phc_r & {3{~clr}});
         mon_r <= monitor_fault_i | (mon_r & {7{~clr}});
      end
   end

   // cycle limit counter; saturates so it never wraps back to zero
   always @* begin
      limit_cnt_nxt = limit_cnt_r;
      if (clr) begin
         limit_cnt_nxt = {`GDSR_CNT_W{1'b0}};
      end
      if (cycle_limit_enable_i && any_oc && limit_cnt_r != {`GDSR_CNT_W{1'b1}}) begin
         limit_cnt_nxt = limit_cnt_r + 1'b1;
      end else if (cycle_limit_enable_i && any_oc) begin
         limit_cnt_nxt = limit_cnt_r;
      end
   end

   always @(posedge core_clk_i) begin
      if (rst_i) begin
         limit_cnt_r <= {`GDSR_CNT_W{1'b0}};
      end else begin
         limit_cnt_r <= limit_cnt_nxt;
      end
   end

   // summaries; user memory flag is left out so it never reaches the pin
   assign ov_any = sup_r[7] | sup_r[5] | sup_r[3] | sup_r[1] | bst_r[5] | bst_r[3] |
                   bst_r[1] | mon_r[6] | mon_r[3];
   assign uv_any = sup_r[6] | sup_r[4] | sup_r[2] | sup_r[0] | bst_r[4] | bst_r[2] |
                   bst_r[0] | mon_r[5] | mon_r[4];
   assign fault_any = (|ds_r) | (|sns_r) | (|gs_r) | ov_any | uv_any | wdt_r | crc_r |
                      addr_r | clk_r | fact_r | shoot_r | dead_r | (|phc_r) |
                      mon_r[2] | mon_r[1] | mon_r[0];
   assign warn_any = psu_warn_r;

   assign summary = {~(wdt_r | crc_r | addr_r | clk_r),
                     fault_any,
                     warn_any,
                     |ds_r, |gs_r, |sns_r, ov_any, uv_any,
                     6'h00,
                     otw_r,
                     driver_enable_ctrl_i};
   assign overcurrent = {(limit_cnt_r != {`GDSR_CNT_W{1'b0}}), 4'h0, sns_r, 2'b00, ds_r};
   assign gate_fault = {10'h000, gs_r};
   assign supply = {sup_r, 2'b00, bst_r};
   assign iface_mem = {1'b0, psu_warn_r, 3'b000, gate_supply_regulator_mode_i,
                       1'b0, wdt_r, crc_r, addr_r, clk_r, fact_r, user_r, 1'b0,
                       shoot_r, dead_r};
   assign monitor = {phc_r, 1'b0, mon_r[6:4], 1'b0, mon_r[3], 2'b00, mon_r[2:1],
                     2'b00, mon_r[0]};

   // address decode; unlisted offsets read as zero
   always @* begin
      if (rd_addr_i == `GDSR_OFS_SUMMARY) begin
         sel_data = summary;
      end else if (rd_addr_i == `GDSR_OFS_OVERCURRENT) begin
         sel_data = overcurrent;
      end else if (rd_addr_i == `GDSR_OFS_GATE_FAULT) begin
         sel_data = gate_fault;
      end else if (rd_addr_i == `GDSR_OFS_SUPPLY) begin
         sel_data = supply;
      end else if (rd_addr_i == `GDSR_OFS_IFACE_MEM) begin
         sel_data = iface_mem;
      end else if (rd_addr_i == `GDSR_OFS_MONITOR) begin
         sel_data = monitor;
      end else begin
         sel_data = `GDSR_RST_ZERO;
      end
   end

   // registered outputs; fault pin and response bit follow the summary one cycle late
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         rd_data_o <= `GDSR_RST_ZERO;
         rd_valid_o <= 1'b0;
         response_fault_bit_o <= 1'b0;
         fault_out_n_o <= 1'b1;
      end else begin
         rd_valid_o <= rd_en_i;
         if (rd_en_i) begin
            rd_data_o <= sel_data;
         end
         response_fault_bit_o <= fault_any;
         fault_out_n_o <= ~fault_any;
      end
   end

endmodule // gdsr_status_bank

// ### gdsr_regs.vh
// register offsets, field positions and reset values of the gate driver status bank
`ifndef GDSR_REGS_VH
`define GDSR_REGS_VH
`define GDSR_OFS_SUMMARY 7'h00
`define GDSR_OFS_OVERCURRENT 7'h01
`define GDSR_OFS_GATE_FAULT 7'h02
`define GDSR_OFS_SUPPLY 7'h03
`define GDSR_OFS_IFACE_MEM 7'h04
`define GDSR_OFS_MONITOR 7'h05
`define GDSR_RST_SUMMARY 16'h8000
`define GDSR_RST_ZERO 16'h0000
`define GDSR_SUM_LINK_OK 15
`define GDSR_SUM_FAULT 14
`define GDSR_SUM_WARN 13
`define GDSR_SUM_DS 12
`define GDSR_SUM_GS 11
`define GDSR_SUM_SNS 10
`define GDSR_SUM_OV 9
`define GDSR_SUM_UV 8
`define GDSR_SUM_OTW 1
`define GDSR_SUM_DRV 0
`define GDSR_OC_LIMIT_ACTIVE 15
`define GDSR_IF_PSU_WARN 14
`define GDSR_IF_GATE_MODE 10
`define GDSR_IF_WDT 8
`define GDSR_IF_CRC 7
`define GDSR_IF_ADDR 6
`define GDSR_IF_CLK 5
`define GDSR_IF_FACT_MEM 4
`define GDSR_IF_USER_MEM 3
`define GDSR_IF_SHOOT 1
`define GDSR_IF_DEAD 0
`define GDSR_CLKS_CRC 7'd32
`define GDSR_CLKS_NOCRC 7'd24
`define GDSR_CLKS_LONG 7'd96
`define GDSR_CNT_W 8
`endif

// ### gdsr_status_bank_properties.sv
// port-level assertions for the status bank
`timescale 1ns/1ps
module gdsr_status_bank_properties (
   input wire core_clk_i, // core clock
   input wire rst_i, // sync reset
   input wire clear_faults_cmd_i, // clear pulse
   input wire driver_enable_ctrl_i, // driver enable
   input wire cycle_limit_enable_i, // limit enable
   input wire [5:0] ds_overcurrent_i, // ds events
   input wire [5:0] gate_fault_i, // gate events
   input wire frame_address_error_i, // address error event
   input wire [6:0] rd_addr_i, // read address
   input wire rd_en_i, // read request
   input wire [15:0] rd_data_o, // read data
   input wire rd_valid_o, // read strobe
   input wire response_fault_bit_o, // leading response bit
   input wire fault_out_n_o // fault pin
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // counting cycle, then a status read two edges on with no clear between
   sequence s_ds_count;
      cycle_limit_enable_i && ds_overcurrent_i != 6'h00 && !clear_faults_cmd_i;
   endsequence
   sequence s_rd0;
      rd_en_i && rd_addr_i == 7'h00;
   endsequence
   sequence s_rd1;
      rd_en_i && rd_addr_i == 7'h01;
   endsequence
   a_read_answer: assert property (rd_en_i |=> rd_valid_o) else $error("read not answered");
   a_valid_pulse: assert property (!rd_en_i |=> !rd_valid_o) else $error("stray read strobe");
   a_lead_bit: assert property (response_fault_bit_o != fault_out_n_o)
      else $error("leading bit differs from fault state");
   a_drv_mirror: assert property (s_rd0 |=> rd_data_o[0] == $past(driver_enable_ctrl_i))
      else $error("driver enable not mirrored");
   a_pin_matches: assert property (rd_valid_o && $past(rd_addr_i) == 7'h00 |->
      rd_data_o[14] != fault_out_n_o) else $error("summary fault bit and pin differ");
   a_unmapped_zero: assert property (rd_en_i && rd_addr_i > 7'h05 |=> rd_data_o == 16'h0000)
      else $error("unmapped address not zero");
   a_gate_pin: assert property (gate_fault_i != 6'h00 ##1 !clear_faults_cmd_i |=>
      !fault_out_n_o) else $error("gate fault did not pull the pin");
   a_limit_count: assert property (s_ds_count ##1 !clear_faults_cmd_i ##1 s_rd1 |=>
      rd_data_o[15]) else $error("limit counter status not set");
   a_link_fault: assert property (frame_address_error_i ##1
      (!clear_faults_cmd_i throughout ##[1:8] s_rd0) |=> !rd_data_o[15])
      else $error("link ok bit still set");
endmodule // gdsr_status_bank_properties

bind gdsr_status_bank gdsr_status_bank_properties u_props (.core_clk_i(core_clk_i),
   .rst_i(rst_i), .clear_faults_cmd_i(clear_faults_cmd_i),
   .driver_enable_ctrl_i(driver_enable_ctrl_i), .cycle_limit_enable_i(cycle_limit_enable_i),
   .ds_overcurrent_i(ds_overcurrent_i), .gate_fault_i(gate_fault_i),
   .frame_address_error_i(frame_address_error_i), .rd_addr_i(rd_addr_i), .rd_en_i(rd_en_i),
   .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
   .response_fault_bit_o(response_fault_bit_o), .fault_out_n_o(fault_out_n_o));

// ### gdsr_mcu_model.sv
// controller model issuing status reads and clear commands
`timescale 1ns/1ps
module gdsr_mcu_model (
   input wire core_clk_i, // core clock
   input wire [15:0] rd_data_o, // read data from the bank
   input wire rd_valid_o, // read strobe from the bank
   output reg req_o, // read request
   output reg [6:0] addr_o, // read address
   output reg clr_o // clear command pulse
);
   initial begin
      req_o = 1'b0;
      addr_o = 7'h7f;
      clr_o = 1'b0;
   end
   // request taken at one edge, answer stands for the cycle after it
   task read(input [6:0] a, output [15:0] d, output v);
      begin
         @(posedge core_clk_i);
         #1 req_o = 1'b1;
         addr_o = a;
         @(posedge core_clk_i);
         #1 req_o = 1'b0;
         addr_o = ~a; // idle address never repeats the last one
         d = rd_data_o;
         v = rd_valid_o;
      end
   endtask
   // one-cycle clear; also sent once after power-up for the user memory flag
   task clear_faults;
      begin
         @(posedge core_clk_i);
         #1 clr_o = 1'b1;
         @(posedge core_clk_i);
         #1 clr_o = 1'b0;
      end
   endtask
endmodule // gdsr_mcu_model

// ### gate_driver_status_registers_tb.sv
// self-checking bench for the status bank
`timescale 1ns/1ps
module gate_driver_status_registers_tb;
   // per event: address nibble, bit nibble, summary high byte
   localparam [767:0] EVT = {192'h5bc2_5ac1_59c1_57c2_54c0_53c0_50c0_5fc0_5ec0_5dc0_0180_40c0,
      192'h41c0_4380_44c0_4640_4740_4840_4ea0_35c2_34c1_33c2_32c1_31c2,
      192'h30c1_3fc2_3ec1_3dc2_3cc1_3bc2_3ac1_39c2_38c1_25c8_24c8_23c8,
      192'h22c8_21c8_20c8_1ac4_19c4_18c4_15d0_14d0_13d0_12d0_11d0_10d0};
   // frame cases: checksum mode, long mode, bad, clock count
   localparam [159:0] FRM = 160'hc17f_4120_4060_0117_0018_8101_8121_811f_8000_8020;
   reg core_clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg [47:0] ev = 48'h0;
   reg drv = 1'b0, lim = 1'b0, gmode = 1'b0, prog = 1'b1, fend = 1'b0, crc_en = 1'b1, lng = 1'b0;
   reg [6:0] cnt = 7'h00;
   wire [15:0] rdata;
   wire rvalid, resp, fault_n, req, clr;
   wire [6:0] addr;
   integer n_fail = 0;
   integer comparisons = 0;
   always #4 core_clk_i = ~core_clk_i;
   gdsr_status_bank DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .clear_faults_cmd_i(clr),
      .driver_enable_ctrl_i(drv), .cycle_limit_enable_i(lim), .ds_overcurrent_i(ev[5:0]),
      .sense_overcurrent_i(ev[8:6]), .gate_fault_i(ev[14:9]), .supply_ov_uv_i(ev[22:15]),
      .bootstrap_ov_uv_i(ev[28:23]), .power_supply_under_warning_i(ev[29]),
      .gate_supply_regulator_mode_i(gmode), .watchdog_timeout_i(ev[30]),
      .frame_checksum_error_i(ev[31]), .frame_address_error_i(ev[32]), .frame_end_i(fend),
      .frame_clock_count_i(cnt), .frame_checksum_enable_i(crc_en), .frame_long_i(lng),
      .factory_memory_checksum_error_i(ev[33]), .user_memory_checksum_error_i(ev[34]),
      .user_memory_programmed_i(prog), .shoot_through_violation_i(ev[35]),
      .dead_time_violation_i(ev[36]), .overtemp_warning_i(ev[37]),
      .phase_compare_fault_i(ev[40:38]), .monitor_fault_i(ev[47:41]), .rd_addr_i(addr),
      .rd_en_i(req), .rd_data_o(rdata), .rd_valid_o(rvalid), .response_fault_bit_o(resp),
      .fault_out_n_o(fault_n));
   gdsr_mcu_model mcu (.core_clk_i(core_clk_i), .rd_data_o(rdata), .rd_valid_o(rvalid),
      .req_o(req), .addr_o(addr), .clr_o(clr));
   task cmp(input string nm, input [15:0] e, input [15:0] s);
      begin
         comparisons = comparisons + 1;
         if (s !== e) begin
            n_fail = n_fail + 1;
            $display("Error %s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   // read one register through the controller model and compare word and strobe
   task chk(input [6:0] a, input [15:0] e);
      reg [15:0] d;
      reg v;
      begin
         mcu.read(a, d, v);
         cmp("rd_valid_o", 16'h0001, {15'h0, v});
         cmp("rd_data_o", e, d);
      end
   endtask
   task t_reset;
      integer i;
      begin
         for (i = 0; i < 7; i = i + 1)
            chk(i, (i == 0) ? 16'h8000 : 16'h0000);
         chk(7'h7f, 16'h0000);
         $display("test reset done");
      end
   endtask
   // each event alone: latched after it drops, shows in its field and summary, then clears
   task t_events;
      integer i;
      reg [15:0] t, e, s;
      begin
         lim = 1'b1;
         for (i = 0; i < 48; i = i + 1) begin
            t = EVT[i*16 +: 16];
            s = {t[7:0], 6'h00, t[15:12] == 4'h0, 1'b0};
            e = (t[15:12] == 4'h0) ? s : (16'h1 << t[11:8]) | {t[15:12] == 4'h1, 15'h0};
            @(posedge core_clk_i);
            #1 ev[i] = 1'b1;
            @(posedge core_clk_i);
            #1 ev[i] = 1'b0;
            chk(t[14:12], e);
            chk(7'h00, s);
            cmp("fault_out_n_o", {15'h0, ~s[14]}, {15'h0, fault_n});
            cmp("response_fault_bit_o", {15'h0, s[14]}, {15'h0, resp});
            mcu.clear_faults();
            chk(t[14:12], (t[15:12] == 4'h0) ? 16'h8000 : 16'h0000);
         end
         lim = 1'b0;
         $display("test events done");
      end
   endtask
   task t_frames;
      integer i;
      reg [15:0] f;
      begin
         for (i = 0; i < 10; i = i + 1) begin
            f = FRM[i*16 +: 16];
            @(posedge core_clk_i);
            #1 crc_en = f[15];
            lng = f[14];
            cnt = f[6:0];
            fend = 1'b1;
            @(posedge core_clk_i);
            #1 fend = 1'b0;
            chk(7'h04, {10'h0, f[8], 5'h0});
            chk(7'h00, {~f[8], f[8], 14'h0});
            mcu.clear_faults();
         end
         $display("test frames done");
      end
   endtask
   task t_live;
      begin
         @(posedge core_clk_i);
         #1 drv = 1'b1;
         gmode = 1'b1;
         prog = 1'b0;
         chk(7'h00, 16'h8001);
         chk(7'h04, 16'h0408);
         cmp("fault_out_n_o", 16'h0001, {15'h0, fault_n});
         cmp("response_fault_bit_o", 16'h0000, {15'h0, resp});
         drv = 1'b0;
         gmode = 1'b0;
         prog = 1'b1;
         mcu.clear_faults();
         chk(7'h04, 16'h0000);
         chk(7'h00, 16'h8000);
         $display("test live bits done");
      end
   endtask
   task stop_test;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, n_fail);
         if (n_fail == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // watchdog well beyond the six hundred or so cycles the tests need
   initial begin
      #200000;
      n_fail = n_fail + 1;
      stop_test;
   end
   initial begin
      repeat (8) @(posedge core_clk_i);
      #1 rst_i = 1'b0;
      mcu.clear_faults();
      t_reset;
      t_events;
      t_frames;
      t_live;
      stop_test;
   end
endmodule // gate_driver_status_registers_tb
